// file: verilog/mode_decode_cfg.svh
/*
  constants of the mode register decoder: bus offsets, field positions,
  reset values and timing counts.
  assumes inclusion by bare name from the package only.
*/
`ifndef MODE_DECODE_CFG_SVH
`define MODE_DECODE_CFG_SVH

// ==========================================================
// register byte offsets
`define OFS_MODE     8'h00
`define OFS_CONFIG   8'h04
`define OFS_STATUS   8'h08

// ==========================================================
// mode word field positions
`define POS_BURST_LO     0
`define POS_BURST_HI     2
`define POS_ORDER        3
`define POS_CAS_LO       4
`define POS_CAS_HI       6
`define POS_TEST         7
`define POS_LOOP_RESET   8
`define POS_WR_LO        9
`define POS_WR_HI        11
`define POS_PD_EXIT      12

// ==========================================================
// encodings and reset values
`define BURST_CODE_4     3'h2
`define BURST_CODE_8     3'h3
`define CAS_MIN          3'h3
`define CAS_MAX          3'h7
`define WR_CODE_MIN      3'h1
`define RST_BURST_CODE   3'h2
`define RST_CAS          3'h3
`define RST_WR_CODE      3'h1
`define RST_POSTED       3'h0
`define POSTED_MAX       3'h6

// ==========================================================
// timing counts, in device clocks
`define LOOP_SETTLE_CYC  8'hC8
`define PIPE_DEPTH       16

`endif

// file: verilog/mode_decode_pkg.sv
/*
  types shared by the mode register decoder.
  assumes mode_decode_cfg.svh is on the include path.
*/
package mode_decode_pkg;
  `include "mode_decode_cfg.svh"

  // ==========================================================
  // command seen on the device clock
  typedef enum logic [2:0] {
    CMD_NOP       = 3'b000,
    CMD_MODE_LOAD = 3'b001,
    CMD_READ      = 3'b010,
    CMD_WRITE     = 3'b011,
    CMD_WRITE_AP  = 3'b100
  } cmd_t;

  // ==========================================================
  // stored mode fields, loop reset bit excluded (self clearing)
  typedef struct packed {
    logic       pd_slow;      // power_down_exit_select
    logic [2:0] wr_code;      // recovery clocks minus one
    logic       test_mode;    // test_mode_bit
    logic [2:0] cas_delay;    // clocks, 3..7
    logic       interleave;   // burst_order_select
    logic [2:0] burst_code;   // burst_size code
  } mode_t;

  // one slot of the latency pipeline
  typedef struct packed {
    logic       valid;
    logic       is_read;
    logic       auto_pre;
    logic [2:0] start;
  } slot_t;

  // burst sequencer states
  typedef enum logic [0:0] {
    SEQ_IDLE  = 1'b0,
    SEQ_BURST = 1'b1
  } seq_state_t;
endpackage

// file: verilog/mode_decode.sv
/*
  mode register decoder of the memory device: takes mode loads, holds
  the mode fields, times reads and writes by the programmed latencies,
  orders burst columns, times write recovery and steers power-down.
  assumes commands arrive from logic on clock_i (no synchroniser) and
  a classic wishbone master for the software registers.
*/
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps

// Function
// - bit 3 picks sequential or interleaved order
// - order from size, type, start column
// - only burst sizes four and eight
// - interleaved offset is start xor k
// - sequential four: ascending, wraps in block
// - sequential eight: nibble wrap, bit2 flips
// - bit7 clear: normal load, program fields
// - bit7 set: fields kept, test mode
// - bit 8 set resets delay loop
// - bit 8 self clears after reset
// - auto precharge delayed by recovery count
// - recovery field encodes 2 to 8 only
// - bit 12 picks fast or slow exit
// - precharge power-down ignores bit 12; slow_exit_o still copies it
// - bits 4-6 hold cas read latency
// - cas latency accepts 3 to 7
// - latency whole clocks only
// - first data at edge n plus m
// - posted delay holds early read
// - bits 0-2 set burst size
// - burst wraps inside aligned block
// - read is posted plus cas; write one less
module mode_decode
  import mode_decode_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // command side, same clock
  input  wire logic        cmd_valid_i,
  input  wire cmd_t        cmd_i,
  input  wire logic [12:0] addr_i,
  input  wire logic        active_pd_i,
  input  wire logic        precharge_pd_i,
  // device side effects
  output logic             loop_reset_o,
  output logic             test_mode_o,
  output logic             data_beat_o,
  output logic             data_read_o,
  output logic [2:0]       col_even_o,
  output logic [2:0]       col_odd_o,
  output logic             precharge_o,
  output logic             loop_freeze_o,
  output logic             slow_exit_o,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  // ==========================================================
  // declarations
  mode_t       mode_ff;                   // loaded mode fields
  logic [2:0]  posted_ff;                 // posted_command_delay
  logic [7:0]  settle_ff;                 // loop settle countdown
  slot_t       pipe_ff [`PIPE_DEPTH];     // latency delay line
  seq_state_t  state_ff;                  // burst sequencer state
  seq_state_t  nxt_state;
  logic [2:0]  start_ff;                  // burst start offset
  logic [1:0]  beat_ff;                   // beat within burst
  logic        auto_pre_ff;               // burst is write with ap
  logic        is_read_ff;                // burst is a read
  logic [3:0]  recov_ff;                  // recovery countdown
  logic        load_ok;                   // a mode load this cycle
  logic        wb_hit;                    // new bus request
  logic [3:0]  read_tap;                  // read_latency_total
  logic [3:0]  write_tap;                 // write latency
  slot_t       rd_slot;
  slot_t       wr_slot;
  slot_t       go_slot;                   // slot starting its data now
  logic [1:0]  last_beat;

  // ==========================================================
  // column order within a burst
  // covers sizes four and eight only, other sizes are never stored
  function automatic logic [2:0] burst_offset(
    input logic [2:0] start,
    input logic [2:0] k,
    input logic       size8,
    input logic       ilv
  );
    logic       hi;
    logic [1:0] lo;
    hi = size8 ? (start[2] ^ k[2]) : start[2];
    lo = ilv ? (start[1:0] ^ k[1:0])
             : 2'(start[1:0] + k[1:0]);
    return {hi, lo};
  endfunction

  // ==========================================================
  // mode load decode
  assign load_ok = cmd_valid_i && (cmd_i == CMD_MODE_LOAD);

  // mode fields; a test-mode load leaves everything else alone
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ff.pd_slow    <= 1'b0;
      mode_ff.wr_code    <= `RST_WR_CODE;
      mode_ff.test_mode  <= 1'b0;
      mode_ff.cas_delay  <= `RST_CAS;
      mode_ff.interleave <= 1'b0;
      mode_ff.burst_code <= `RST_BURST_CODE;
    end else if (load_ok) begin
      if (addr_i[`POS_TEST]) begin
        mode_ff.test_mode <= 1'b1;
      end else begin
        mode_ff.test_mode  <= 1'b0;
        mode_ff.interleave <= addr_i[`POS_ORDER];
        mode_ff.pd_slow    <= addr_i[`POS_PD_EXIT];
        // reserved codes keep the old size
        if (addr_i[`POS_BURST_HI:`POS_BURST_LO] == `BURST_CODE_4 ||
            addr_i[`POS_BURST_HI:`POS_BURST_LO] == `BURST_CODE_8) begin
          mode_ff.burst_code <= addr_i[`POS_BURST_HI:`POS_BURST_LO];
        end
        // latency 3..7 whole clocks; others ignored
        if (addr_i[`POS_CAS_HI:`POS_CAS_LO] >= `CAS_MIN) begin
          mode_ff.cas_delay <= addr_i[`POS_CAS_HI:`POS_CAS_LO];
        end
        // code 0 is reserved; 1..7 give 2..8 clocks
        if (addr_i[`POS_WR_HI:`POS_WR_LO] >= `WR_CODE_MIN) begin
          mode_ff.wr_code <= addr_i[`POS_WR_HI:`POS_WR_LO];
        end
      end
    end
  end
  // fields otherwise hold between loads

  // ==========================================================
  // loop reset pulse and settle timer
  // the stored image never holds bit 8, so readback shows it clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_reset_o <= 1'b0;
      settle_ff    <= 8'h00;
    end else begin
      loop_reset_o <= load_ok && !addr_i[`POS_TEST]
                      && addr_i[`POS_LOOP_RESET];
      if (load_ok && !addr_i[`POS_TEST] && addr_i[`POS_LOOP_RESET]) begin
        settle_ff <= `LOOP_SETTLE_CYC;
      end else if (settle_ff != 8'h00) begin
        settle_ff <= settle_ff - 8'h01;
      end
    end
  end

  // ==========================================================
  // latency delay line; slot i holds a command i+1 edges old
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `PIPE_DEPTH; i++) begin
        pipe_ff[i] <= '0;
      end
    end else begin
      pipe_ff[0].valid    <= cmd_valid_i && (cmd_i == CMD_READ ||
                             cmd_i == CMD_WRITE || cmd_i == CMD_WRITE_AP);
      pipe_ff[0].is_read  <= cmd_i == CMD_READ;
      pipe_ff[0].auto_pre <= cmd_i == CMD_WRITE_AP;
      pipe_ff[0].start    <= addr_i[2:0];
      for (int i = 1; i < `PIPE_DEPTH; i++) begin
        pipe_ff[i] <= pipe_ff[i-1];
      end
    end
  end

  // taps: read after posted+cas, write one clock sooner
  always_comb begin
    read_tap  = 4'({1'b0, posted_ff} + {1'b0, mode_ff.cas_delay});
    write_tap = 4'(read_tap - 4'h1);
    rd_slot   = pipe_ff[4'(read_tap - 4'h2)];
    wr_slot   = pipe_ff[4'(write_tap - 4'h2)];
    // reads win a clash; the controller never overlaps data anyway
    if (rd_slot.valid && rd_slot.is_read) begin
      go_slot = rd_slot;
    end else if (wr_slot.valid && !wr_slot.is_read) begin
      go_slot = wr_slot;
    end else begin
      go_slot = '0;
    end
    last_beat = (mode_ff.burst_code == `BURST_CODE_8) ? 2'h3 : 2'h1;
  end

  // ==========================================================
  // burst sequencer, two columns per clock
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SEQ_IDLE: begin
        if (go_slot.valid) begin
          nxt_state = SEQ_BURST;
        end
      end
      SEQ_BURST: begin
        // back-to-back burst restarts, else finish
        if (beat_ff == last_beat && !go_slot.valid) begin
          nxt_state = SEQ_IDLE;
        end
      end
      default: begin
        nxt_state = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff    <= SEQ_IDLE;
      beat_ff     <= 2'h0;
      start_ff    <= 3'h0;
      auto_pre_ff <= 1'b0;
      is_read_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (go_slot.valid && (state_ff == SEQ_IDLE || beat_ff == last_beat)) begin
        beat_ff     <= 2'h0;
        start_ff    <= go_slot.start;
        auto_pre_ff <= go_slot.auto_pre;
        is_read_ff  <= go_slot.is_read;
      end else if (state_ff == SEQ_BURST) begin
        beat_ff <= beat_ff + 2'h1;
      end
    end
  end

  // registered column outputs, launched on the edge the beat starts so
  // that the first read beat is seen at edge n + read_latency_total, a write's one edge sooner
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_beat_o <= 1'b0;
      data_read_o <= 1'b0;
      col_even_o  <= 3'h0;
      col_odd_o   <= 3'h0;
    end else if (go_slot.valid && (state_ff == SEQ_IDLE || beat_ff == last_beat)) begin
      // first beat of a new burst
      data_beat_o <= 1'b1;
      data_read_o <= go_slot.is_read;
      col_even_o  <= burst_offset(go_slot.start, 3'h0,
                       mode_ff.burst_code == `BURST_CODE_8,
                       mode_ff.interleave);
      col_odd_o   <= burst_offset(go_slot.start, 3'h1,
                       mode_ff.burst_code == `BURST_CODE_8,
                       mode_ff.interleave);
    end else if (state_ff == SEQ_BURST && beat_ff != last_beat) begin
      // following beats of the running burst
      data_beat_o <= 1'b1;
      data_read_o <= is_read_ff;
      col_even_o  <= burst_offset(start_ff, {2'(beat_ff + 2'h1), 1'b0},
                       mode_ff.burst_code == `BURST_CODE_8,
                       mode_ff.interleave);
      col_odd_o   <= burst_offset(start_ff, {2'(beat_ff + 2'h1), 1'b1},
                       mode_ff.burst_code == `BURST_CODE_8,
                       mode_ff.interleave);
    end else begin
      // columns hold, beat flags drop
      data_beat_o <= 1'b0;
      data_read_o <= 1'b0;
    end
  end

  // ==========================================================
  // write recovery before the internal precharge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      recov_ff    <= 4'h0;
      precharge_o <= 1'b0;
    end else begin
      precharge_o <= recov_ff == 4'h1;
      if (state_ff == SEQ_BURST && beat_ff == last_beat
          && auto_pre_ff && !is_read_ff) begin
        recov_ff <= {1'b0, mode_ff.wr_code};
      end else if (recov_ff != 4'h0) begin
        recov_ff <= recov_ff - 4'h1;
      end
    end
  end

  // ==========================================================
  // power-down steering; precharge power-down keeps loop_freeze_o low whatever bit 12 holds, slow_exit_o copies bit 12 always
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_freeze_o <= 1'b0;
      slow_exit_o   <= 1'b0;
    end else begin
      loop_freeze_o <= active_pd_i && !precharge_pd_i
                       && mode_ff.pd_slow;
      slow_exit_o   <= mode_ff.pd_slow;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      test_mode_o <= 1'b0;
    end else begin
      test_mode_o <= mode_ff.test_mode;
    end
  end

  // ==========================================================
  // wishbone slave: ack one clock after the request, dropped after
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      posted_ff <= `RST_POSTED;
    end else begin
      wb_ack_o <= wb_hit;
      // write lands on the ack edge, where the master samples ack high
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
          && wb_adr_i == `OFS_CONFIG) begin
        // reserved delays above six are refused
        if (wb_dat_i[2:0] <= `POSTED_MAX) begin
          posted_ff <= wb_dat_i[2:0];
        end
      end
      case (wb_adr_i)
        `OFS_MODE: begin
          wb_dat_o <= {19'h0, mode_ff.pd_slow, mode_ff.wr_code, 1'b0,
                       mode_ff.test_mode, mode_ff.cas_delay,
                       mode_ff.interleave, mode_ff.burst_code};
        end
        `OFS_CONFIG: begin
          wb_dat_o <= {29'h0, posted_ff};
        end
        `OFS_STATUS: begin
          wb_dat_o <= {29'h0, state_ff == SEQ_BURST,
                       settle_ff != 8'h00, mode_ff.test_mode};
        end
        default: begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

// file: verification/mode_decode_properties.sv
/*
  port checker of the mode decoder, bound into every instance.
  assumes one clock and a posted delay that changes only over the bus.
*/
`timescale 1ns/1ps
module mode_decode_properties
  import mode_decode_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        cmd_valid_i,
  input wire cmd_t        cmd_i,
  input wire logic [12:0] addr_i,
  input wire logic        active_pd_i,
  input wire logic        precharge_pd_i,
  input wire logic        loop_reset_o,
  input wire logic        test_mode_o,
  input wire logic        data_beat_o,
  input wire logic        data_read_o,
  input wire logic        precharge_o,
  input wire logic        loop_freeze_o,
  input wire logic        slow_exit_o,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o
);
  // ==========================================================
  // shadow of the latency fields and of the command history
  logic [2:0]  cas_ff;   // cas delay in force
  logic [2:0]  post_ff;  // posted delay in force
  logic [15:0] rd_ff;    // bit k: read taken k+1 clocks ago
  logic [15:0] wr_ff;    // bit k: write taken k+1 clocks ago
  logic        ld;       // mode load this cycle
  logic        dll;      // normal load asking for a loop reset
  logic [3:0]  rl;       // total read latency
  assign ld  = cmd_valid_i && cmd_i == CMD_MODE_LOAD;
  assign dll = ld && addr_i[8] && !addr_i[7];
  assign rl  = {1'b0, cas_ff} + {1'b0, post_ff};
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // reserved cas codes and test loads keep the old value
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cas_ff <= 3'h3;
    end else if (ld && !addr_i[7] && addr_i[6:4] >= 3'h3) begin
      cas_ff <= addr_i[6:4];
    end
  end
  // bus write lands on its ack edge; values above six are refused
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      post_ff <= 3'h0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h04
                 && wb_sel_i[0] && wb_dat_i[2:0] <= 3'h6) begin
      post_ff <= wb_dat_i[2:0];
    end
  end
  // command history, deep enough for the largest latency
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ff <= 16'h0;
      wr_ff <= 16'h0;
    end else begin
      rd_ff <= {rd_ff[14:0], cmd_valid_i && cmd_i == CMD_READ};
      wr_ff <= {wr_ff[14:0], cmd_valid_i && (cmd_i == CMD_WRITE || cmd_i == CMD_WRITE_AP)};
    end
  end
  // ==========================================================
  // assertions
  a_loop_pulse: assert property (dll |=> loop_reset_o ##1 !loop_reset_o)
    else $error("loop reset pulse wrong");
  a_loop_cause: assert property (loop_reset_o |-> $past(dll))
    else $error("loop reset without a load");
  a_test_entry: assert property (ld && addr_i[7] |-> ##2 test_mode_o)
    else $error("test mode not entered");
  a_test_leave: assert property (ld && !addr_i[7] |-> ##2 !test_mode_o)
    else $error("test mode not left");
  a_exit_load: assert property (ld && !addr_i[7] |-> ##2 slow_exit_o == $past(addr_i[12], 2))
    else $error("exit select not loaded");
  a_exit_kept: assert property (ld && addr_i[7] |-> ##2 $stable(slow_exit_o))
    else $error("exit select changed by test load");
  a_freeze_on: assert property (active_pd_i && !precharge_pd_i
                                |=> loop_freeze_o == slow_exit_o)
    else $error("loop freeze wrong");
  a_freeze_off: assert property (!active_pd_i || precharge_pd_i |=> !loop_freeze_o)
    else $error("loop frozen outside active power down");
  a_read_lat: assert property (rd_ff[rl - 4'h1] |-> data_beat_o && data_read_o)
    else $error("read data late");
  a_write_lat: assert property (wr_ff[rl - 4'h2] |-> data_beat_o)
    else $error("write data late");
  a_beat_cause: assert property ($rose(data_beat_o) |-> rd_ff[rl - 4'h1] || wr_ff[rl - 4'h2])
    else $error("data beat too early");
  a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack wrong");
  c_read: cover property (data_beat_o && data_read_o);
  c_prech: cover property (precharge_o);
  c_loop: cover property (loop_reset_o);
  c_test: cover property (test_mode_o);
endmodule

bind mode_decode mode_decode_properties i_mode_decode_properties (.*);

// file: verification/ddr2_ctrl_model.sv
/*
  memory controller model: issues mode loads and column commands.
  assumes send() is called just after a rising clock edge.
*/
`timescale 1ns/1ps
module ddr2_ctrl_model
  import mode_decode_pkg::*;
#(
  parameter int MODE_LOAD_GAP = 2  // idle clocks after a mode load
)(
  input  wire logic   clock_i,
  output logic        cmd_valid_o,
  output cmd_t        cmd_o,
  output logic [12:0] addr_o
);
  int cyc     = 0;      // free clock count
  int loop_at = -1000;  // clock of the last loop reset
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o       = CMD_NOP;
    addr_o      = 13'h0000;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
  end
  // recovery clocks from a time in ns at 5 ns, rounded up
  function automatic int wr_clk(input int ns);
    return (ns + 4) / 5;
  endfunction
  // raw lets a scenario break the rules on purpose
  task automatic send(input cmd_t c, input logic [12:0] a, input logic raw);
    int i;
    for (i = 0; i < 300 && c == CMD_READ && cyc - loop_at < 200; i++) begin
      @(posedge clock_i);
    end
    cmd_valid_o <= 1'b1;
    cmd_o       <= c;
    addr_o      <= raw ? a : (a & 13'h1F7F);
    @(posedge clock_i);
    cmd_valid_o <= 1'b0;
    cmd_o       <= CMD_NOP;
    addr_o      <= ~a;  // released lines show no stale value
    if (c == CMD_MODE_LOAD) begin
      if (a[8]) begin
        loop_at = cyc;
      end
      repeat (MODE_LOAD_GAP) @(posedge clock_i);
    end
  endtask
endmodule

// file: verification/mode_decode_tb.sv
/*
  self-checking bench of the mode decoder.
  assumes the package, checker and controller model compile first.
*/
`timescale 1ns/1ps
module mode_decode_tb
  import mode_decode_pkg::*;
;
  // ==========================================================
  // stimulus, outputs and expected mode fields
  logic        clock_i        = 1'b0;
  logic        rst_n_i        = 1'b0;
  logic        active_pd_i    = 1'b0;
  logic        precharge_pd_i = 1'b0;
  logic        wb_cyc_i       = 1'b0;
  logic        wb_stb_i       = 1'b0;
  logic        wb_we_i        = 1'b0;
  logic [7:0]  wb_adr_i       = 8'h00;
  logic [3:0]  wb_sel_i       = 4'h0;
  logic [31:0] wb_dat_i       = 32'h0;
  logic        cmd_valid_i;
  cmd_t        cmd_i;
  logic [12:0] addr_i;
  logic        loop_reset_o, test_mode_o, data_beat_o, data_read_o;
  logic        precharge_o, loop_freeze_o, slow_exit_o, wb_ack_o;
  logic [2:0]  col_even_o, col_odd_o;
  logic [31:0] wb_dat_o;
  logic [2:0]  bc = 3'h2, cas = 3'h3, wr = 3'h1, post = 3'h0;
  logic        ord = 1'b0, pd = 1'b0, tm = 1'b0;
  int          err_total = 0;
  int          comparisons = 0;
  always #2.5 clock_i = ~clock_i;
  mode_decode i_mode_decode (.*);
  ddr2_ctrl_model i_ddr2_ctrl_model (.clock_i(clock_i), .cmd_valid_o(cmd_valid_i),
                                     .cmd_o(cmd_i), .addr_o(addr_i));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // a wait that ran out ends the run as a mismatch
  task automatic lim(input int i, input int n);
    if (i >= n) begin
      err_total++;
      summarize();
    end
  endtask
  // one classic cycle; holds everything until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int i;
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    for (i = 0; i < 20; i++) begin
      @(posedge clock_i);
      if (wb_ack_o === 1'b1) break;
    end
    r = wb_dat_o;
    lim(i, 20);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  function automatic logic [31:0] mw();
    return {19'h0, pd, wr, 1'b0, tm, cas, ord, bc};
  endfunction
  // column of access k for a start column, under the mirrored mode
  function automatic logic [2:0] off(input logic [2:0] s, input int k);
    logic [2:0] kk;
    kk = 3'(k);
    if (ord) return (bc == 3'h3) ? s ^ kk : {s[2], s[1:0] ^ kk[1:0]};
    return {(bc == 3'h3) ? s[2] ^ kk[2] : s[2], s[1:0] + kk[1:0]};
  endfunction
  // mirror the load, issue it, read the mode word back
  task automatic load(input logic [12:0] a, input logic raw);
    logic [31:0] r;
    if (a[7]) begin
      tm = 1'b1;
    end else begin
      tm  = 1'b0;
      pd  = a[12];
      ord = a[3];
      if (a[11:9] != 3'h0) wr = a[11:9];
      if (a[6:4] >= 3'h3) cas = a[6:4];
      if (a[2:1] == 2'b01) bc = a[2:0];
    end
    i_ddr2_ctrl_model.send(CMD_MODE_LOAD, a, raw);
    wb(1'b0, 8'h00, 32'h0, r);
    chk(r, mw());
  endtask
  // issue one column command, check latency, columns and precharge
  task automatic burst(input cmd_t c, input logic [2:0] s);
    int i;
    int j;
    int w;
    w = (c == CMD_READ) ? 0 : 1;
    i_ddr2_ctrl_model.send(c, {10'h0, s}, 1'b0);
    for (i = 1; i < 40; i++) begin
      @(posedge clock_i);
      if (data_beat_o === 1'b1) break;
    end
    lim(i, 40);
    chk(i, cas + post - w);
    for (j = 0; j < ((bc == 3'h3) ? 4 : 2); j++) begin
      chk({col_even_o, col_odd_o, data_read_o}, {off(s, 2 * j), off(s, 2 * j + 1), !w});
      @(posedge clock_i);
    end
    chk(data_beat_o, 1'b0);
    if (c == CMD_WRITE_AP) begin
      for (i = 1; i < 20; i++) begin
        if (precharge_o === 1'b1) break;
        @(posedge clock_i);
      end
      chk(i, wr + 1);
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] r;
    int          t;
    logic [12:0] a;
    void'($urandom(34963));
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    wb(1'b1, 8'h00, 32'h1FFF, r);
    wb(1'b0, 8'h00, 32'h0, r);
    chk(r, mw());
    wb(1'b0, 8'h08, 32'h0, r);
    chk(r, 32'h0);
    wb(1'b0, 8'h10, 32'h0, r);
    chk(r, 32'h0);
    wb(1'b1, 8'h04, 32'h7, r);
    wb(1'b0, 8'h04, 32'h0, r);
    chk(r, 32'h0);
    // every size, order and start column, random latencies
    for (t = 0; t < 32; t++) begin
      post = 3'($urandom_range(6, 0));
      wb(1'b1, 8'h04, {29'h0, post}, r);
      a = {1'($urandom_range(1, 0)), 3'(i_ddr2_ctrl_model.wr_clk($urandom_range(40, 6)) - 1),
           2'b00, 3'($urandom_range(7, 3)), t[0], 2'b01, t[1]};
      load(a, 1'b0);
      burst(CMD_READ, 3'(t >> 2));
      burst(CMD_WRITE_AP, 3'($urandom));
    end
    // every code of burst, cas and recovery, reserved ones kept
    for (t = 0; t < 8; t++) begin
      load({1'b0, 3'(t), 2'b00, 3'(t), 1'b0, 3'(t)}, 1'b1);
    end
    load(13'h0132, 1'b0);
    wb(1'b0, 8'h08, 32'h0, r);
    chk(r, 32'h2);
    burst(CMD_READ, 3'h5);
    load(13'h1FFF, 1'b1);
    chk(test_mode_o, 1'b1);
    load(13'h0232, 1'b0);
    chk(test_mode_o, 1'b0);
    // power down variants against the exit select
    for (t = 0; t < 8; t++) begin
      load({t[2], 12'h232}, 1'b0);
      active_pd_i    <= t[0];
      precharge_pd_i <= t[1];
      repeat (2) @(posedge clock_i);
      chk(loop_freeze_o, t[0] & t[2] & !t[1]);
      chk(slow_exit_o, t[2]);
    end
    summarize();
  end
  initial begin
    repeat (90000) @(posedge clock_i);
    err_total++;
    summarize();
  end
endmodule
